//--- inc/bsc_pkg.sv
// Constants and carrier types for the BAR setup register bank.
package bsc_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] BAR_LO_OFS   = 12'h010;
   localparam logic [11:0] BAR_HI_OFS   = 12'h014;
   localparam logic [11:0] SETUP_OFS    = 12'h470;

   // ----------------------------------------------------------------
   // Setup register field positions
   // ----------------------------------------------------------------
   localparam int          SPACE_POS    = 0;
   localparam int          TYPE_LSB     = 1;
   localparam int          PREFETCHABLE_SELECT_POS     = 3;
   localparam int          SIZE_LSB     = 4;
   localparam int          MODE_POS     = 10;
   localparam int          XLAT_LSB     = 11;
   localparam int          TPART_LSB    = 13;
   localparam int          EN_POS       = 31;

   // ----------------------------------------------------------------
   // Reset values, masks and encodings
   // ----------------------------------------------------------------
   localparam logic [31:0] SETUP_RST    = 32'h0000_0000;
   localparam logic [31:0] SETUP_WMASK  = 32'h8000_e7ff;
   localparam logic [5:0]  SIZE_MIN     = 6'h04;
   localparam logic [1:0]  DEC_32       = 2'h0;
   localparam logic [1:0]  DEC_64       = 2'h2;
   localparam int          BASE_ADDRESS_BITS_LSB    = 4;
   localparam int          THIRTY_TWO_BIT_DECODE_TOP   = 32;
   localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [11:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } bsc_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } bsc_wb_rsp_t;

   typedef struct packed {
      logic        en;
      logic        cfg_map;
      logic        dec64;
      logic        prefetch;
      logic [5:0]  size;
      logic [2:0]  tpart;
   } bsc_bar_out_t;

   typedef struct packed {
      logic [31:0]       setup;
      logic [63:4]       base;
      bsc_wb_rsp_t       rsp;
      bsc_bar_out_t      bar;
   } bsc_state_t;

endpackage

//--- rtl/bsc_top.sv
// BAR setup register bank with the BAR it shapes, on a classic Wishbone slave.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Setup bit 0 is the space indicator that the BAR reports, zero for memory space.
// - Setup bits 2:1 give the reported decode type, zero for 32-bit and two for 64-bit.
// - Setup bit 3 gives the prefetchable attribute that the BAR reports.
// - Setup bits 9:4 give the window size as two to the power of the field, in bytes.
// - The lowest base-address bit of the BAR stands for address bit 4, and upward.
// - With a size of four or more, base-address bits at or above the size position are writable.
// - Base-address bits from position four up to below the size read zero and drop writes.
// - A size below four makes every base-address bit read-only zero but leaves the BAR enabled.
// - Under 32-bit decoding, address bits at and above 32 are ignored whatever the size.
// - Setup bit 10 selects address window (zero) or mapped configuration space (one).
// - With the enable bit 31 clear the BAR reads zero and all setup values are ignored.
module bsc_top (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire bsc_pkg::bsc_wb_req_t wb_i,
   output var  bsc_pkg::bsc_wb_rsp_t wb_o,
   output logic                      bar_en_o,
   output logic                      bar_cfg_map_o,
   output logic                      bar_dec64_o,
   output logic                      bar_prefetch_o,
   output logic [5:0]                bar_size_o,
   output logic [2:0]                bar_tpart_o,
   output logic [63:4]               bar_base_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bsc_pkg::bsc_state_t st_q;
   bsc_pkg::bsc_state_t st_d;

   logic                en;
   logic                dec64;
   logic [5:0]          size;
   logic [63:4]         wmask;
   logic [63:4]         base_vis;
   logic [31:0]         bar_lo_rd;
   logic [31:0]         bar_hi_rd;
   logic [31:0]         rd_data;
   logic [31:0]         byte_m;
   logic [31:0]         lo_m;
   logic [31:0]         hi_m;
   logic [31:0]         lo_new;
   logic [31:0]         hi_new;
   logic                req;
   logic                wr_now;

   assign en    = st_q.setup[bsc_pkg::EN_POS];
   assign size  = st_q.setup[bsc_pkg::SIZE_LSB +: 6];
   assign dec64 = (st_q.setup[bsc_pkg::TYPE_LSB +: 2] == bsc_pkg::DEC_64);

   // ----------------------------------------------------------------
   // Writable mask of the base-address bits
   // ----------------------------------------------------------------
   // Each mask bit stands for one bus address bit, so bit 4 of the mask is
   // the lowest base-address bit of the BAR.
   generate
      for (genvar a = bsc_pkg::BASE_ADDRESS_BITS_LSB; a < 64; a++) begin : g_mask
         localparam logic [6:0] APOS = 7'(a);
         assign wmask[a] = en
                         && (size >= bsc_pkg::SIZE_MIN)
                         && ({1'b0, size} <= APOS)
                         && ((a < bsc_pkg::THIRTY_TWO_BIT_DECODE_TOP) || dec64);
      end
   endgenerate

   // The read-back is masked by the present setup, so a narrower window or a
   // cleared enable shows on the very next read.
   assign base_vis = st_q.base & wmask;

   // ----------------------------------------------------------------
   // Read-back of the BAR pair
   // ----------------------------------------------------------------
   // Reserved space and type encodings are reported exactly as stored; only
   // type two opens the upper word of the pair.
   always_comb begin
      bar_lo_rd = 32'h0000_0000;
      bar_hi_rd = 32'h0000_0000;
      if (en) begin
         bar_lo_rd[31:4] = base_vis[31:4];
         bar_lo_rd[bsc_pkg::SPACE_POS] = st_q.setup[bsc_pkg::SPACE_POS];
         bar_lo_rd[bsc_pkg::TYPE_LSB +: 2] = st_q.setup[bsc_pkg::TYPE_LSB +: 2];
         bar_lo_rd[bsc_pkg::PREFETCHABLE_SELECT_POS] = st_q.setup[bsc_pkg::PREFETCHABLE_SELECT_POS];
         bar_hi_rd = base_vis[63:32];
      end
   end

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // A request is answered one cycle after it is taken, with no wait states; a
   // request still seen while ack is high is not taken again.
   assign req    = wb_i.cyc & wb_i.stb;
   assign wr_now = req & wb_i.we & st_q.rsp.ack;
   assign byte_m = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}},
                    {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
   assign lo_m   = byte_m & {wmask[31:4], 4'h0};
   assign hi_m   = byte_m & wmask[63:32];
   // Unwritten lanes keep the masked base, so a bit that the mask has cut can
   // never come back through a partial write.
   assign lo_new = ({base_vis[31:4], 4'h0} & ~lo_m) | (wb_i.dat & lo_m);
   assign hi_new = (base_vis[63:32] & ~hi_m) | (wb_i.dat & hi_m);

   always_comb begin
      case (wb_i.adr)
         bsc_pkg::SETUP_OFS:  rd_data = st_q.setup;
         bsc_pkg::BAR_LO_OFS: rd_data = bar_lo_rd;
         bsc_pkg::BAR_HI_OFS: rd_data = bar_hi_rd;
         default:             rd_data = bsc_pkg::RD_UNMAPPED;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d         = st_q;
      st_d.base    = base_vis;
      st_d.rsp.ack = req & ~st_q.rsp.ack;
      if (req && !st_q.rsp.ack) begin
         st_d.rsp.dat = rd_data;
      end
      // Writes land on the edge that sees ack high, as the master expects.
      if (wr_now) begin
         case (wb_i.adr)
            bsc_pkg::SETUP_OFS: begin
               st_d.setup = (st_q.setup & ~(byte_m & bsc_pkg::SETUP_WMASK))
                          | (wb_i.dat & byte_m & bsc_pkg::SETUP_WMASK);
            end
            bsc_pkg::BAR_LO_OFS: begin
               st_d.base[31:4] = lo_new[31:4];
            end
            bsc_pkg::BAR_HI_OFS: begin
               st_d.base[63:32] = hi_new;
            end
            default: begin
               st_d.base = base_vis;
            end
         endcase
      end
      // The outputs are registered copies of what the same edge stores in the
      // setup register, so a consumer never sees a decode glitch.
      st_d.bar.en       = st_d.setup[bsc_pkg::EN_POS];
      st_d.bar.cfg_map  = st_d.bar.en & st_d.setup[bsc_pkg::MODE_POS];
      st_d.bar.dec64    = st_d.bar.en
                        & (st_d.setup[bsc_pkg::TYPE_LSB +: 2] == bsc_pkg::DEC_64);
      st_d.bar.prefetch = st_d.bar.en & st_d.setup[bsc_pkg::PREFETCHABLE_SELECT_POS];
      st_d.bar.size     = st_d.bar.en ? st_d.setup[bsc_pkg::SIZE_LSB +: 6] : 6'h00;
      st_d.bar.tpart    = st_d.bar.en ? st_d.setup[bsc_pkg::TPART_LSB +: 3] : 3'h0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q.setup <= bsc_pkg::SETUP_RST;
         st_q.base  <= 60'h0;
         st_q.rsp   <= '0;
         st_q.bar   <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // All outputs are flops; the base lags a setup write by one cycle, which
   // no bus read can observe since reads answer from the live mask.
   assign wb_o           = st_q.rsp;
   assign bar_en_o       = st_q.bar.en;
   assign bar_cfg_map_o  = st_q.bar.cfg_map;
   assign bar_dec64_o    = st_q.bar.dec64;
   assign bar_prefetch_o = st_q.bar.prefetch;
   assign bar_size_o     = st_q.bar.size;
   assign bar_tpart_o    = st_q.bar.tpart;
   assign bar_base_o     = st_q.base;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // The read qualifiers mark the edge at which read data is captured, so each
   // read check looks at the data one cycle later, while ack stands.
   logic rd_lo;
   logic rd_hi;
   logic rd_set;
   logic rd_other;
   assign rd_lo = req & ~wb_i.we & ~st_q.rsp.ack & (wb_i.adr == bsc_pkg::BAR_LO_OFS);
   assign rd_hi = req & ~wb_i.we & ~st_q.rsp.ack & (wb_i.adr == bsc_pkg::BAR_HI_OFS);
   assign rd_set = req & ~wb_i.we & ~st_q.rsp.ack & (wb_i.adr == bsc_pkg::SETUP_OFS);
   assign rd_other = req & ~wb_i.we & ~st_q.rsp.ack & ~rd_lo & ~rd_hi & ~rd_set;

   property p_ack_one;
      req && !wb_o.ack |=> wb_o.ack;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack not given one cycle after request");

   property p_ack_drop;
      wb_o.ack |=> !wb_o.ack;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack held longer than one cycle");

   property p_dis_zero;
      rd_lo && !en |=> wb_o.dat == 32'h0000_0000;
   endproperty
   a_dis_zero: assert property (p_dis_zero) else $error("disabled BAR read non-zero");

   property p_space;
      rd_lo && en |=> wb_o.dat[0] == $past(st_q.setup[0]);
   endproperty
   a_space: assert property (p_space) else $error("space indicator mismatch");

   property p_type;
      rd_lo && en |=> wb_o.dat[2:1] == $past(st_q.setup[2:1]);
   endproperty
   a_type: assert property (p_type) else $error("decode type mismatch");

   property p_prefetchable_select;
      rd_lo && en |=> wb_o.dat[3] == $past(st_q.setup[3]);
   endproperty
   a_prefetchable_select: assert property (p_prefetchable_select) else $error("prefetchable mismatch");

   property p_small;
      rd_lo && (size < bsc_pkg::SIZE_MIN) |=> wb_o.dat[31:4] == 28'h0;
   endproperty
   a_small: assert property (p_small) else $error("small size left base bits");

   property p_low_zero;
      rd_lo && en && (size == 6'h0c) |=> wb_o.dat[11:4] == 8'h00;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("bits below size not zero");

   property p_hi32;
      rd_hi && !dec64 |=> wb_o.dat == 32'h0000_0000;
   endproperty
   a_hi32: assert property (p_hi32) else $error("upper BAR non-zero in 32-bit");

   property p_wr_lo;
      wr_now && (wb_i.adr == bsc_pkg::BAR_LO_OFS) && (wb_i.sel == 4'hf)
         |=> st_q.base[31:4] == $past(wb_i.dat[31:4] & wmask[31:4]);
   endproperty
   a_wr_lo: assert property (p_wr_lo) else $error("base write not applied");

   property p_wr_hi;
      wr_now && (wb_i.adr == bsc_pkg::BAR_HI_OFS) && (wb_i.sel == 4'hf)
         |=> st_q.base[63:32] == $past(wb_i.dat & wmask[63:32]);
   endproperty
   a_wr_hi: assert property (p_wr_hi) else $error("upper base write not applied");

   property p_lo_live;
      rd_lo |=> wb_o.dat[31:4] == $past(st_q.base[31:4] & wmask[31:4]);
   endproperty
   a_lo_live: assert property (p_lo_live) else $error("low base not live-masked");

   property p_dis_out;
      !bar_en_o |-> !bar_cfg_map_o && !bar_dec64_o && !bar_prefetch_o
                    && (bar_size_o == 6'h00) && (bar_tpart_o == 3'h0);
   endproperty
   a_dis_out: assert property (p_dis_out) else $error("disabled BAR drives setup");

   property p_dis_base;
      !en |=> st_q.base == 60'h0;
   endproperty
   a_dis_base: assert property (p_dis_base) else $error("disabled BAR kept base bits");

   property p_small_hi;
      rd_hi && (size < bsc_pkg::SIZE_MIN) |=> wb_o.dat == 32'h0000_0000;
   endproperty
   a_small_hi: assert property (p_small_hi) else $error("small size left upper bits");

   property p_rd_set;
      rd_set |=> wb_o.dat == $past(st_q.setup);
   endproperty
   a_rd_set: assert property (p_rd_set) else $error("setup read-back mismatch");

   property p_unmapped;
      rd_other |=> wb_o.dat == bsc_pkg::RD_UNMAPPED;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read non-zero");

   property p_setup_ro;
      (st_q.setup & ~bsc_pkg::SETUP_WMASK) == 32'h0000_0000;
   endproperty
   a_setup_ro: assert property (p_setup_ro) else $error("read-only setup bits set");

   // ----------------------------------------------------------------
   // Cover points
   // ----------------------------------------------------------------
   c_rd_lo:  cover property (rd_lo && en ##1 wb_o.ack);
   c_wr_set: cover property (wr_now && (wb_i.adr == bsc_pkg::SETUP_OFS));
   c_rd_hi:  cover property (rd_hi && dec64 && en);
   c_rd_dis: cover property (rd_lo && !en ##1 wb_o.ack);
   c_cfg:    cover property (bar_cfg_map_o && (bar_size_o == 6'h0c));

endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the BAR setup register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ----------------------------------------------------------------
   // Clock, reset and bench state
   // ----------------------------------------------------------------
   logic                 clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   bsc_pkg::bsc_wb_req_t wb_i = '0;
   bsc_pkg::bsc_wb_rsp_t wb_o;
   logic                 en, map, d64, pf;
   logic [5:0]           sz;
   logic [2:0]           tp;
   logic [63:4]          base;
   int                   fail_count = 0;
   int                   cmp_count = 0;
   int                   cyc_n = 0;
   logic [31:0]          rnd = 32'h2295;
   logic [31:0]          m_set = '0;
   logic [63:0]          m_base = '0;
   logic [31:0]          rd;
   logic [31:0]          nset;
   logic [5:0]           sizes [8] = '{6'h00, 6'h03, 6'h04, 6'h07, 6'h0c, 6'h1f, 6'h20, 6'h3f};

   always #2.5 clk_i = ~clk_i;

   bsc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .bar_en_o(en),
      .bar_cfg_map_o(map), .bar_dec64_o(d64), .bar_prefetch_o(pf), .bar_size_o(sz),
      .bar_tpart_o(tp), .bar_base_o(base));

   // A hung handshake would stretch every bus task to 50 cycles, so a cycle ceiling cuts the run short.
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 5000) begin
         fail_count++;
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // Reference model and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic [63:0] wmask(input logic [31:0] s);
      logic [63:0] m;
      m = '0;
      for (int a = 4; a < 64; a++)
         m[a] = s[31] && s[9:4] >= 6'h04 && a >= int'(s[9:4]) && (a < 32 || s[2:1] == 2'h2);
      return m;
   endfunction

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wb(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_o.ack !== 1'b1 && n < 50);
      chk("wb_ack", 64'h1, {63'h0, wb_o.ack});
      rd = wb_o.dat;
      wb_i <= '0;
   endtask

   task automatic wr(input logic [11:0] adr, input logic [3:0] sel, input logic [31:0] d);
      logic [63:0] m;
      logic [31:0] l;
      wb(1'b1, adr, sel, d);
      l = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      if (adr == bsc_pkg::SETUP_OFS) begin
         m_set = (m_set & ~(l & bsc_pkg::SETUP_WMASK)) | (d & l & bsc_pkg::SETUP_WMASK);
         m_base &= wmask(m_set);
      end
      m = wmask(m_set);
      if (adr == bsc_pkg::BAR_LO_OFS)
         m_base[31:0] = (m_base[31:0] & ~(l & m[31:0])) | (d & l & m[31:0]);
      if (adr == bsc_pkg::BAR_HI_OFS)
         m_base[63:32] = (m_base[63:32] & ~(l & m[63:32])) | (d & l & m[63:32]);
   endtask

   task automatic check_all();
      logic [31:0] s;
      s = m_set;
      wb(1'b0, bsc_pkg::SETUP_OFS, 4'hf, '0);
      chk("setup", s, rd);
      wb(1'b0, bsc_pkg::BAR_LO_OFS, 4'hf, '0);
      chk("bar_lo", s[31] ? {m_base[31:4], s[3:0]} : 32'h0, rd);
      wb(1'b0, bsc_pkg::BAR_HI_OFS, 4'hf, '0);
      chk("bar_hi", (s[31] && s[2:1] == 2'h2) ? m_base[63:32] : 32'h0, rd);
      chk("bar_en", s[31], en);
      chk("cfg_map", s[31] & s[10], map);
      chk("dec64", s[31] && s[2:1] == 2'h2, d64);
      chk("prefetch", s[31] & s[3], pf);
      chk("size", s[31] ? s[9:4] : 6'h0, sz);
      chk("tpart", s[31] ? s[15:13] : 3'h0, tp);
      chk("base", m_base[63:4], base);
   endtask

   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      check_all();
      wr(12'h100, 4'hf, 32'hffff_ffff);
      wb(1'b0, 12'h100, 4'hf, '0);
      chk("unmapped", 32'h0, rd);
      wr(bsc_pkg::SETUP_OFS, 4'hf, 32'h8000_04c0);
      wr(bsc_pkg::BAR_LO_OFS, 4'hf, 32'hffff_ffff);
      check_all();
      for (int i = 0; i < 60; i++) begin
         rnd = lfsr(rnd);
         nset = rnd;
         // Early passes walk the size corners, including sizes software should avoid.
         if (i < 16) begin
            nset[9:4] = sizes[i % 8];
            nset[2:1] = (i < 8) ? 2'h0 : 2'h2;
            nset[10] = 1'b0;
         end else if (nset[10]) begin
            // Mapping mode needs the 4 KB window; the bench sets it here, as the DUT does not enforce it.
            nset[9:4] = 6'h0c;
         end
         nset[31] = (i % 5 != 4);
         wr(bsc_pkg::SETUP_OFS, 4'hf, nset);
         rnd = lfsr(rnd);
         wr(bsc_pkg::BAR_LO_OFS, rnd[3:0], rnd);
         rnd = lfsr(rnd);
         wr(bsc_pkg::BAR_HI_OFS, rnd[7:4], rnd);
         check_all();
      end
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      m_set = '0;
      m_base = '0;
      check_all();
      complete_run();
   end
endmodule
`default_nettype wire
